// ---- design/asrc_ctrl.sv ----
// Host controller driving an asynchronous 16-bit static memory
// Contract
// - Data setup/hold referenced to write-ending edge.
// - Strobe write at least float plus setup.
// - Controller never drives while device drives.
// - Read address valid by select falling edge.
`timescale 1ns/1ps
module asrc_ctrl
  import asrc_pkg::*;
(
  // Clock and reset
  input  wire logic                           core_clk_in,
  input  wire logic                           reset_n_in,
  // User request
  input  wire logic                           req_valid_in,
  input  wire logic                           req_write_in,
  input  wire logic [asrc_pkg::ADDR_W-1:0]    req_addr_in,
  input  wire logic [asrc_pkg::DATA_W-1:0]    req_wdata_in,
  input  wire logic [1:0]                     req_byte_en_in,
  output logic                                req_ready_out,
  output logic [asrc_pkg::DATA_W-1:0]         rdata_out,
  output logic                                rdata_valid_out,
  // Memory pins
  output logic [asrc_pkg::ADDR_W-1:0]         sram_addr_out,
  output logic                                chip_sel_n_out,
  output logic                                write_strobe_n_out,
  output logic                                out_drive_n_out,
  output logic                                upper_byte_sel_n_out,
  output logic                                lower_byte_sel_n_out,
  output logic [asrc_pkg::DATA_W-1:0]         sram_data_out,
  output logic                                sram_data_oe_out,
  input  wire logic [asrc_pkg::DATA_W-1:0]    sram_data_in
);
  import asrc_pkg::*;

  asrc_state_t             state;
  asrc_state_t             next_state;
  logic [CNT_W-1:0]        cnt;
  logic [CNT_W-1:0]        next_cnt;
  logic [DATA_W-1:0]       sync1;
  logic [DATA_W-1:0]       sync2;
  logic [1:0]              byte_en;
  logic                    is_write;

  wire idle      = (state == ASRC_IDLE);
  wire accept    = idle && req_valid_in;
  wire cnt_done_rd = (cnt == RD_LAST);
  wire cnt_done_wr = (cnt == WR_LAST);
  wire cnt_done_tn = (cnt == TURN_LAST);
  wire sel_phase = (state == ASRC_READ) || (state == ASRC_WSET) || (state == ASRC_WPULSE);
  wire rd_phase  = (state == ASRC_READ);
  wire drv_phase = (state == ASRC_WSET) || (state == ASRC_WPULSE) || (state == ASRC_WHOLD);

  assign req_ready_out = idle;
  // Select only in an access, standby otherwise
  assign chip_sel_n_out = !sel_phase;
  // Strobe low only inside the select window
  assign write_strobe_n_out = !(state == ASRC_WPULSE);
  // Output drive low only in reads, high during writes
  assign out_drive_n_out = !rd_phase;
  // Byte lanes follow the request
  assign lower_byte_sel_n_out = !(sel_phase && byte_en[0]);
  assign upper_byte_sel_n_out = !(sel_phase && byte_en[1]);
  // Data driven only while device output drive is off
  assign sram_data_oe_out = drv_phase && is_write;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      ASRC_IDLE: begin
        next_cnt = CNT_RST;
        if (req_valid_in) begin
          next_state = req_write_in ? ASRC_WSET : ASRC_READ;
        end
      end
      ASRC_READ: begin
        next_cnt = cnt + 4'h1;
        if (cnt_done_rd) begin
          next_state = ASRC_TURN;
          next_cnt = CNT_RST;
        end
      end
      ASRC_TURN: begin
        next_cnt = cnt + 4'h1;
        if (cnt_done_tn) begin
          next_state = ASRC_IDLE;
        end
      end
      ASRC_WSET: begin
        next_state = ASRC_WPULSE;
        next_cnt = CNT_RST;
      end
      ASRC_WPULSE: begin
        next_cnt = cnt + 4'h1;
        if (cnt_done_wr) begin
          next_state = ASRC_WHOLD;
        end
      end
      ASRC_WHOLD: begin
        next_state = ASRC_IDLE;
      end
      default: begin
        next_state = ASRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= ASRC_IDLE;
      cnt <= CNT_RST;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Address and write data held from select fall to access end
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sram_addr_out <= ADDR_RST;
      sram_data_out <= DATA_RST;
      byte_en <= 2'h0;
      is_write <= 1'b0;
    end else if (accept) begin
      sram_addr_out <= req_addr_in;
      sram_data_out <= req_wdata_in;
      byte_en <= req_byte_en_in;
      is_write <= req_write_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1 <= DATA_RST;
      sync2 <= DATA_RST;
    end else begin
      sync1 <= sram_data_in;
      sync2 <= sync1;
    end
  end

  // Capture read word as the read window closes, unselected lanes zero
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= DATA_RST;
      rdata_valid_out <= 1'b0;
    end else begin
      rdata_valid_out <= rd_phase && cnt_done_rd;
      if (rd_phase && cnt_done_rd) begin
        rdata_out <= {byte_en[1] ? sync2[15:8] : 8'h00, byte_en[0] ? sync2[7:0] : 8'h00};
      end
    end
  end

  data_no_clash_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    sram_data_oe_out |-> out_drive_n_out && !$past(rd_phase))
    else $error("Data driven while device may drive");

  read_addr_stable_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (!chip_sel_n_out && $past(!chip_sel_n_out)) |-> $stable(sram_addr_out) && write_strobe_n_out || !rd_phase)
    else $error("Read address moved while selected");

  write_setup_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $rose(write_strobe_n_out) |-> $past(sram_data_oe_out, 2) && $stable(sram_data_out) && sram_data_oe_out)
    else $error("Write data not stable around write end");

  write_length_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $fell(write_strobe_n_out) |-> !write_strobe_n_out[*2] ##1 write_strobe_n_out)
    else $error("Write pulse length wrong");

  write_in_select_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !write_strobe_n_out |-> !chip_sel_n_out && out_drive_n_out)
    else $error("Strobe outside select window");

  idle_quiet_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    idle |-> chip_sel_n_out && write_strobe_n_out && !sram_data_oe_out)
    else $error("Pins active while idle");

  read_no_drive_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !out_drive_n_out |-> !sram_data_oe_out && write_strobe_n_out)
    else $error("Controller drives bus during read");

  read_window_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $fell(out_drive_n_out) |-> !out_drive_n_out[*4] ##1 out_drive_n_out)
    else $error("Read window length wrong");

  read_answer_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $fell(out_drive_n_out) |-> ##4 rdata_valid_out)
    else $error("Read word not returned on time");

  valid_pulse_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    rdata_valid_out |=> !rdata_valid_out)
    else $error("Read valid longer than one cycle");

  write_data_setup_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $fell(write_strobe_n_out) |-> $past(sram_data_oe_out) && !chip_sel_n_out)
    else $error("Write data not driven before strobe");

  write_data_hold_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $fell(sram_data_oe_out) |-> $past(write_strobe_n_out) && chip_sel_n_out)
    else $error("Write data released before write end");

  write_end_joint_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $rose(write_strobe_n_out) |-> $rose(chip_sel_n_out))
    else $error("Select and strobe not ending together");

  write_addr_steady_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !write_strobe_n_out |-> $stable(sram_addr_out) && $stable(sram_data_out))
    else $error("Address or data moved during write");
endmodule

// ---- design/asrc_pkg.sv ----
// Constants for the asynchronous static memory controller
package asrc_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int WORDS = 262144;
  localparam int CLK_MHZ = 25;
  // Device times in ns
  localparam int READ_CYCLE_NS = 70;
  localparam int WRITE_END_NS = 60;
  localparam int WRITE_PULSE_NS = 40;
  localparam int WRITE_TO_FLOAT_DELAY_NS = 25;
  localparam int DATA_SETUP_TIME_NS = 30;
  localparam int OUT_FLOAT_NS = 20;
  // Least times round up to whole cycles
  localparam int RD_CYC = (READ_CYCLE_NS * CLK_MHZ + 999) / 1000;
  localparam int WE_MIN_NS = (WRITE_TO_FLOAT_DELAY_NS + DATA_SETUP_TIME_NS > WRITE_END_NS)
                           ? WRITE_TO_FLOAT_DELAY_NS + DATA_SETUP_TIME_NS : WRITE_END_NS;
  localparam int WR_RAW = (WE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_CYC = (WR_RAW < 1) ? 1 : WR_RAW;
  localparam int TURN_CYC = (OUT_FLOAT_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_STAGES = 2;
  localparam int RD_HOLD = RD_CYC + SYNC_STAGES;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(RD_HOLD - 1);
  localparam logic [CNT_W-1:0] WR_LAST = CNT_W'(WR_CYC - 1);
  localparam logic [CNT_W-1:0] TURN_LAST = CNT_W'(TURN_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  typedef enum logic [2:0] {
    ASRC_IDLE,
    ASRC_READ,
    ASRC_TURN,
    ASRC_WSET,
    ASRC_WPULSE,
    ASRC_WHOLD
  } asrc_state_t;
endpackage

// ---- testbench/asrc_sram_model.sv ----
// Behavioural static memory on the far side
`timescale 1ns/1ps
module asrc_sram_model
  import asrc_pkg::*;
(
  // Pins
  input  wire logic [asrc_pkg::ADDR_W-1:0] a_in,
  input  wire logic                        cs_n_in,
  input  wire logic                        we_n_in,
  input  wire logic                        oe_n_in,
  input  wire logic                        upper_byte_sel_n_in,
  input  wire logic                        lower_byte_sel_n_in,
  input  wire logic [asrc_pkg::DATA_W-1:0] bus_in,
  // Float pattern and drive
  input  wire logic [asrc_pkg::DATA_W-1:0] noise_in,
  output logic      [asrc_pkg::DATA_W-1:0] dq_out,
  output logic      [1:0]                  dq_en_out
);
  import asrc_pkg::*;
  logic [DATA_W-1:0] mem [WORDS];
  wire rd = !cs_n_in && we_n_in && !oe_n_in;
  wire wr = !cs_n_in && !we_n_in;
  assign dq_en_out = rd ? {!upper_byte_sel_n_in, !lower_byte_sel_n_in} : 2'b00;
  assign dq_out = {dq_en_out[1] ? mem[a_in][15:8] : noise_in[15:8], dq_en_out[0] ? mem[a_in][7:0] : noise_in[7:0]};
  initial for (int i = 0; i < WORDS; i++) mem[i] = 16'h0000;
  always @* begin
    if (wr && !lower_byte_sel_n_in) mem[a_in][7:0] = bus_in[7:0];
    if (wr && !upper_byte_sel_n_in) mem[a_in][15:8] = bus_in[15:8];
  end
endmodule

// ---- testbench/async_sram_word_byte_access_test.sv ----
// Self-checking bench for the static memory controller
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module async_sram_word_byte_access_test;
  import asrc_pkg::*;
  logic core_clk_in = 0, reset_n_in = 0, req_valid_in = 0, req_write_in = 0;
  logic [ADDR_W-1:0] req_addr_in = 18'h00000, sram_addr;
  logic [DATA_W-1:0] req_wdata_in = 16'h0000, noise = 16'h0000, rdata_out, wdata, dq, bus;
  logic [1:0]        req_byte_en_in = 2'h0, dq_en;
  logic              req_ready_out, rdata_valid_out, cs_n, we_n, oe_n, ub_n, lb_n, data_oe;
  logic [31:0]       seed = 32'hdebc2831;
  logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
  int                mismatches = 0, comparisons = 0;
  assign bus = data_oe ? wdata : dq;
  asrc_ctrl dut_u (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .req_valid_in(req_valid_in),
    .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .req_byte_en_in(req_byte_en_in), .req_ready_out(req_ready_out), .rdata_out(rdata_out),
    .rdata_valid_out(rdata_valid_out), .sram_addr_out(sram_addr), .chip_sel_n_out(cs_n),
    .write_strobe_n_out(we_n), .out_drive_n_out(oe_n), .upper_byte_sel_n_out(ub_n),
    .lower_byte_sel_n_out(lb_n), .sram_data_out(wdata), .sram_data_oe_out(data_oe), .sram_data_in(bus));
  asrc_sram_model sram_u (.a_in(sram_addr), .cs_n_in(cs_n), .we_n_in(we_n), .oe_n_in(oe_n),
    .upper_byte_sel_n_in(ub_n), .lower_byte_sel_n_in(lb_n), .bus_in(bus), .noise_in(noise),
    .dq_out(dq), .dq_en_out(dq_en));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic [15:0] mask(input logic [1:0] be);
    return {{8{be[1]}}, {8{be[0]}}};
  endfunction
  function automatic logic [15:0] word(input logic [17:0] a);
    return shadow.exists(a) ? shadow[a] : 16'h0000;
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic op(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [1:0] be);
    int n, nv, nw;
    logic [15:0] got;
    n = 0;
    nv = 0;
    nw = 0;
    got = 16'h0000;
    @(negedge core_clk_in);
    req_valid_in = 1;
    req_write_in = w;
    req_addr_in = a;
    req_wdata_in = d;
    req_byte_en_in = be;
    while (req_ready_out !== 1'b1 && n < 20) begin
      @(negedge core_clk_in);
      n++;
    end
    if (n == 20) begin
      mismatches++;
      give_verdict();
    end
    @(negedge core_clk_in);
    req_valid_in = 0;
    repeat (8) begin
      if (rdata_valid_out === 1'b1) begin
        nv++;
        got = rdata_out;
      end
      if (we_n === 1'b0) nw++;
      @(negedge core_clk_in);
    end
    if (w) begin
      `CHK(nw, WR_CYC)
      `CHK(nv, 0)
      shadow[a] = (word(a) & ~mask(be)) | (d & mask(be));
    end else begin
      `CHK(nv, 1)
      `CHK(got, word(a) & mask(be))
      `CHK(nw, 0)
    end
    $display("op w=%0d a=%h be=%h done", w, a, be);
  endtask
  always @(posedge core_clk_in) noise <= noise + 16'h9e37;
  always @(negedge core_clk_in) if (data_oe === 1'b1) `CHK(dq_en, 2'b00)
  initial forever #20 core_clk_in = ~core_clk_in;
  initial begin
    repeat (3) @(negedge core_clk_in);
    `CHK({cs_n, we_n, data_oe}, 3'b110)
    reset_n_in = 1;
    for (int b = 0; b < 4; b++) begin
      op(1, 18'h3ffff, 16'(16'h5a00 + b), b[1:0]);
      op(0, 18'h3ffff, 16'h0000, 2'b11);
      op(0, 18'h00000, 16'h0000, b[1:0]);
    end
    for (int i = 0; i < 60; i++) begin
      seed = xs(seed);
      op(seed[0], {{15{seed[1]}}, seed[4:2]}, seed[31:16], seed[6:5]);
    end
    give_verdict();
  end
endmodule
